// file: logic/sensor_setup_regs.svh
// Register map, test multiplexer codes, reset values and frame lengths of the sensor setup block.
// Assumes a 100 MHz mclk; addresses are 7 bits inside a 2-bit bank.
`ifndef SENSOR_SETUP_REGS_SVH
`define SENSOR_SETUP_REGS_SVH

// Bank select register, reachable from every bank
`define ADDR_BANK_SEL 7'h7f
// Bank 0
`define ADDR_CLK_RELEASE 7'h03
`define ADDR_CTRL_SCHEME 7'h09
`define ADDR_LINE_LO 7'h16
`define ADDR_LINE_HI 7'h17
`define ADDR_CHAN_COUNT 7'h1a
`define ADDR_PLL1_EN 7'h6a
`define ADDR_PREDIV 7'h6b
`define ADDR_MAIN_MULT 7'h6c
`define ADDR_RATE_SEL 7'h6d
`define ADDR_PLL2_EN 7'h6e
`define ADDR_AUX_MULT 7'h70
`define ADDR_PLL_COMMON_EN 7'h72
`define ADDR_LOCK_STATE 7'h73
`define ADDR_TEST_MUX 7'h78
// Bank 1
`define ADDR_GRANULE 7'h05
`define ADDR_DUMMIES 7'h2e
`define ADDR_TG_LO 7'h6e
`define ADDR_TG_HI 7'h6f
`define ADDR_SLAG_LO 7'h72
`define ADDR_SLAG_HI 7'h73
// Bank 3
`define ADDR_IFACE_0 7'h01
`define ADDR_IFACE_1 7'h02
`define ADDR_IFACE_2 7'h03
`define ADDR_SRST_HOLD 7'h31

// Test multiplexer codes
`define TMUX_PLL1_LOCK 8'h01
`define TMUX_PLL2_LOCK 8'h02

// Reset values
`define RST_BYTE 8'h00
`define RST_CHAN_COUNT 8'h16
`define RST_SRST_HOLD 1'b1

// Frame length on the serial port
`define SPI_FRAME_BITS 5'h10
`define SPI_CMD_BITS 5'h08

`endif

// file: logic/sensor_setup_pkg.sv
// Types shared by the sensor setup block and its bench.
// Constants live in sensor_setup_regs.svh.
package sensor_setup_pkg;

   typedef enum logic [1:0] {BANK0, BANK1, BANK2, BANK3} bank_e;

   typedef enum logic [1:0] {SPI_IDLE, SPI_CMD, SPI_DATA} spi_state_e;

   // Settings handed to the two loops; loop 1 output is the conversion clock
   typedef struct packed {
      logic pll1_en;
      logic pll2_en;
      logic common_en;
      logic [7:0] prediv;
      logic [7:0] rate_sel;
      logic [7:0] main_mult;
      logic [7:0] aux_mult;
   } pll_cfg_s;

   typedef struct packed {
      logic [7:0] granule;
      logic [3:0] dummies;
      logic [13:0] tg_span;
      logic [13:0] shutter_delay;
   } shutter_s;

   typedef struct packed {
      logic [7:0] channel_count;
      logic [7:0] control_scheme;
      logic [15:0] line_period;
      logic [7:0] iface0;
      logic [7:0] iface1;
      logic [7:0] iface2;
   } readout_s;

endpackage : sensor_setup_pkg

// file: logic/sensor_clock_reset_setup.sv
// Serial register port and start-up configuration store of the sensor:
// loop setup, lock status, soft reset, channel count, shutter timing, control scheme.
// Assumes sclk, cs_n, mosi and the two lock flags come from outside mclk's domain.
`timescale 1ns/1ps
`include "sensor_setup_regs.svh"

module sensor_clock_reset_setup (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   input wire logic pll1_lock_raw,
   input wire logic pll2_lock_raw,
   output logic test_out_pin,
   output logic soft_reset,
   output logic core_clk_en,
   output sensor_setup_pkg::pll_cfg_s pll_cfg,
   output sensor_setup_pkg::shutter_s shutter_cfg,
   output sensor_setup_pkg::readout_s readout_cfg
);

   // Address match in the selected bank
   function automatic logic hit(input logic [1:0] bank, input logic [6:0] addr,
                                input logic [1:0] want_bank, input logic [6:0] want_addr);
      hit = (bank == want_bank) && (addr == want_addr);
   endfunction : hit

   // Channel counts the output multiplexer supports
   function automatic logic chan_ok(input logic [7:0] v);
      chan_ok = (v == 8'h16) || (v == 8'h0b) || (v == 8'h08) || (v == 8'h06) ||
                (v == 8'h05) || (v == 8'h04) || (v == 8'h03) || (v == 8'h02) ||
                (v == 8'h01);
   endfunction : chan_ok

   logic [2:0] sclk_s_q;
   logic [1:0] cs_s_q;
   logic [1:0] mosi_s_q;
   logic [1:0] lock1_s_q;
   logic [1:0] lock2_s_q;
   logic sclk_rise;
   logic sclk_fall;
   sensor_setup_pkg::spi_state_e state_q;
   logic [4:0] bit_cnt_q;
   logic [15:0] shift_q;
   logic [7:0] tx_q;
   logic wr_stb_q;
   logic [6:0] wr_addr_q;
   logic [7:0] wr_data_q;
   logic [1:0] bank_q;
   logic [7:0] clk_release_q;
   logic srst_hold_q;
   logic [7:0] test_mux_q;
   sensor_setup_pkg::pll_cfg_s pll_q;
   sensor_setup_pkg::shutter_s shut_q;
   sensor_setup_pkg::readout_s ro_q;
   logic [7:0] rd_data;
   logic [7:0] lock_state;
   logic miso_q;
   logic miso_oe_q;
   logic test_out_q;
   logic soft_reset_q;
   logic core_clk_en_q;

   // Two-stage synchronisers; third sclk stage only for edge finding
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sclk_s_q <= 3'h0;
         cs_s_q <= 2'h3;
         mosi_s_q <= 2'h0;
         lock1_s_q <= 2'h0;
         lock2_s_q <= 2'h0;
      end else begin
         sclk_s_q <= {sclk_s_q[1:0], sclk};
         cs_s_q <= {cs_s_q[0], cs_n};
         mosi_s_q <= {mosi_s_q[0], mosi};
         lock1_s_q <= {lock1_s_q[0], pll1_lock_raw};
         lock2_s_q <= {lock2_s_q[0], pll2_lock_raw};
      end
   end

   assign sclk_rise = sclk_s_q[1] && !sclk_s_q[2];
   assign sclk_fall = !sclk_s_q[1] && sclk_s_q[2];

   // Both loops locked reads 3, partial lock 1 or 2, none 0
   assign lock_state = {6'h00, lock2_s_q[1], lock1_s_q[1]};

   // Read data mux over the selected bank
   always_comb begin
      rd_data = 8'h00;
      if (shift_q[6:0] == `ADDR_BANK_SEL) begin
         rd_data = {6'h00, bank_q};
      end else begin
         unique case (bank_q)
            2'h0: begin
               case (shift_q[6:0])
                  `ADDR_CLK_RELEASE: rd_data = clk_release_q;
                  `ADDR_CTRL_SCHEME: rd_data = ro_q.control_scheme;
                  `ADDR_LINE_LO: rd_data = ro_q.line_period[7:0];
                  `ADDR_LINE_HI: rd_data = ro_q.line_period[15:8];
                  `ADDR_CHAN_COUNT: rd_data = ro_q.channel_count;
                  `ADDR_PLL1_EN: rd_data = {7'h00, pll_q.pll1_en};
                  `ADDR_PREDIV: rd_data = pll_q.prediv;
                  `ADDR_MAIN_MULT: rd_data = pll_q.main_mult;
                  `ADDR_RATE_SEL: rd_data = pll_q.rate_sel;
                  `ADDR_PLL2_EN: rd_data = {7'h00, pll_q.pll2_en};
                  `ADDR_AUX_MULT: rd_data = pll_q.aux_mult;
                  `ADDR_PLL_COMMON_EN: rd_data = {7'h00, pll_q.common_en};
                  `ADDR_LOCK_STATE: rd_data = lock_state;
                  `ADDR_TEST_MUX: rd_data = test_mux_q;
                  default: rd_data = 8'h00;
               endcase
            end
            2'h1: begin
               case (shift_q[6:0])
                  `ADDR_GRANULE: rd_data = shut_q.granule;
                  `ADDR_DUMMIES: rd_data = {4'h0, shut_q.dummies};
                  `ADDR_TG_LO: rd_data = shut_q.tg_span[7:0];
                  `ADDR_TG_HI: rd_data = {2'h0, shut_q.tg_span[13:8]};
                  `ADDR_SLAG_LO: rd_data = shut_q.shutter_delay[7:0];
                  `ADDR_SLAG_HI: rd_data = {2'h0, shut_q.shutter_delay[13:8]};
                  default: rd_data = 8'h00;
               endcase
            end
            2'h2: rd_data = 8'h00;
            2'h3: begin
               case (shift_q[6:0])
                  `ADDR_IFACE_0: rd_data = ro_q.iface0;
                  `ADDR_IFACE_1: rd_data = ro_q.iface1;
                  `ADDR_IFACE_2: rd_data = ro_q.iface2;
                  `ADDR_SRST_HOLD: rd_data = {7'h00, srst_hold_q};
                  default: rd_data = 8'h00;
               endcase
            end
         endcase
      end
   end

   // Frame engine: command byte then data byte, MSB first
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_q <= sensor_setup_pkg::SPI_IDLE;
         bit_cnt_q <= 5'h00;
         shift_q <= 16'h0000;
         tx_q <= 8'h00;
         wr_stb_q <= 1'b0;
         wr_addr_q <= 7'h00;
         wr_data_q <= 8'h00;
      end else begin
         wr_stb_q <= 1'b0;
         if (cs_s_q[1]) begin
            state_q <= sensor_setup_pkg::SPI_IDLE;
            bit_cnt_q <= 5'h00;
            tx_q <= 8'h00; // Cut frame leaves no stale read byte
         end else begin
            unique case (state_q)
               sensor_setup_pkg::SPI_IDLE: begin
                  state_q <= sensor_setup_pkg::SPI_CMD;
                  bit_cnt_q <= 5'h00;
               end
               sensor_setup_pkg::SPI_CMD: begin
                  if (sclk_rise) begin
                     shift_q <= {shift_q[14:0], mosi_s_q[1]};
                     bit_cnt_q <= bit_cnt_q + 5'h01;
                     if (bit_cnt_q == `SPI_CMD_BITS - 5'h01) begin
                        state_q <= sensor_setup_pkg::SPI_DATA;
                     end
                  end
               end
               sensor_setup_pkg::SPI_DATA: begin
                  if (bit_cnt_q == `SPI_CMD_BITS && !sclk_rise && tx_q == 8'h00) begin
                     tx_q <= rd_data;
                  end
                  if (sclk_fall && bit_cnt_q != `SPI_CMD_BITS) begin // MSB stands to ninth rise
                     tx_q <= {tx_q[6:0], 1'b0};
                  end
                  if (sclk_rise) begin
                     shift_q <= {shift_q[14:0], mosi_s_q[1]};
                     bit_cnt_q <= bit_cnt_q + 5'h01;
                     if (bit_cnt_q == `SPI_FRAME_BITS - 5'h01) begin
                        wr_stb_q <= shift_q[14];
                        wr_addr_q <= shift_q[13:7];
                        wr_data_q <= {shift_q[6:0], mosi_s_q[1]};
                        state_q <= sensor_setup_pkg::SPI_IDLE;
                        tx_q <= 8'h00;
                     end
                  end
               end
               default: state_q <= sensor_setup_pkg::SPI_IDLE;
            endcase
         end
      end
   end

   // Bank selection for all later accesses
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bank_q <= 2'h0;
      end else if (wr_stb_q && wr_addr_q == `ADDR_BANK_SEL) begin
         bank_q <= wr_data_q[1:0];
      end
   end

   // Loop settings; first loop output is the conversion clock
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pll_q <= '0;
      end else if (wr_stb_q) begin
         if (hit(bank_q, wr_addr_q, 2'h0, `ADDR_PLL1_EN)) pll_q.pll1_en <= wr_data_q[0];
         if (hit(bank_q, wr_addr_q, 2'h0, `ADDR_PLL2_EN)) pll_q.pll2_en <= wr_data_q[0];
         if (hit(bank_q, wr_addr_q, 2'h0, `ADDR_PLL_COMMON_EN)) pll_q.common_en <= wr_data_q[0];
         if (hit(bank_q, wr_addr_q, 2'h0, `ADDR_PREDIV)) pll_q.prediv <= wr_data_q;
         if (hit(bank_q, wr_addr_q, 2'h0, `ADDR_RATE_SEL)) pll_q.rate_sel <= wr_data_q;
         if (hit(bank_q, wr_addr_q, 2'h0, `ADDR_MAIN_MULT)) pll_q.main_mult <= wr_data_q;
         if (hit(bank_q, wr_addr_q, 2'h0, `ADDR_AUX_MULT)) pll_q.aux_mult <= wr_data_q;
      end
   end

   // Soft reset controls and test multiplexer select
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         clk_release_q <= `RST_BYTE;
         srst_hold_q <= `RST_SRST_HOLD;
         test_mux_q <= `RST_BYTE;
      end else if (wr_stb_q) begin
         if (hit(bank_q, wr_addr_q, 2'h0, `ADDR_CLK_RELEASE)) clk_release_q <= wr_data_q;
         if (hit(bank_q, wr_addr_q, 2'h3, `ADDR_SRST_HOLD)) srst_hold_q <= wr_data_q[0];
         if (hit(bank_q, wr_addr_q, 2'h0, `ADDR_TEST_MUX)) test_mux_q <= wr_data_q;
      end
   end

   // Readout settings; illegal channel counts and schemes are dropped
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ro_q <= '0;
         ro_q.channel_count <= `RST_CHAN_COUNT;
      end else if (wr_stb_q) begin
         if (hit(bank_q, wr_addr_q, 2'h0, `ADDR_CHAN_COUNT) && chan_ok(wr_data_q)) begin
            ro_q.channel_count <= wr_data_q;
         end
         if (hit(bank_q, wr_addr_q, 2'h0, `ADDR_CTRL_SCHEME) && wr_data_q < 8'h04) begin
            ro_q.control_scheme <= wr_data_q;
         end
         if (hit(bank_q, wr_addr_q, 2'h0, `ADDR_LINE_LO)) ro_q.line_period[7:0] <= wr_data_q;
         if (hit(bank_q, wr_addr_q, 2'h0, `ADDR_LINE_HI)) ro_q.line_period[15:8] <= wr_data_q;
         if (hit(bank_q, wr_addr_q, 2'h3, `ADDR_IFACE_0)) ro_q.iface0 <= wr_data_q;
         if (hit(bank_q, wr_addr_q, 2'h3, `ADDR_IFACE_1)) ro_q.iface1 <= wr_data_q;
         if (hit(bank_q, wr_addr_q, 2'h3, `ADDR_IFACE_2)) ro_q.iface2 <= wr_data_q;
      end
   end

   // Shutter timing fields, upper bits of narrow fields dropped
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         shut_q <= '0;
      end else if (wr_stb_q) begin
         if (hit(bank_q, wr_addr_q, 2'h1, `ADDR_GRANULE)) shut_q.granule <= wr_data_q;
         if (hit(bank_q, wr_addr_q, 2'h1, `ADDR_DUMMIES)) shut_q.dummies <= wr_data_q[3:0];
         if (hit(bank_q, wr_addr_q, 2'h1, `ADDR_TG_LO)) shut_q.tg_span[7:0] <= wr_data_q;
         if (hit(bank_q, wr_addr_q, 2'h1, `ADDR_TG_HI)) shut_q.tg_span[13:8] <= wr_data_q[5:0];
         if (hit(bank_q, wr_addr_q, 2'h1, `ADDR_SLAG_LO)) begin
            shut_q.shutter_delay[7:0] <= wr_data_q;
         end
         if (hit(bank_q, wr_addr_q, 2'h1, `ADDR_SLAG_HI)) begin
            shut_q.shutter_delay[13:8] <= wr_data_q[5:0];
         end
      end
   end

   // Soft reset gates clocks only; loops keep their enables
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         soft_reset_q <= 1'b1;
         core_clk_en_q <= 1'b0;
      end else begin
         soft_reset_q <= srst_hold_q || !clk_release_q[0];
         core_clk_en_q <= !srst_hold_q && clk_release_q[0] && (lock_state == 8'h03);
      end
   end

   // Lock indication onto the test pin, and serial output drive
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         test_out_q <= 1'b0;
         miso_q <= 1'b0;
         miso_oe_q <= 1'b0;
      end else begin
         test_out_q <= (test_mux_q == `TMUX_PLL1_LOCK) ? lock1_s_q[1] :
                       (test_mux_q == `TMUX_PLL2_LOCK) ? lock2_s_q[1] : 1'b0;
         miso_q <= tx_q[7];
         miso_oe_q <= (state_q == sensor_setup_pkg::SPI_DATA) && !cs_s_q[1];
      end
   end

   assign miso = miso_q;
   assign miso_oe = miso_oe_q;
   assign test_out_pin = test_out_q;
   assign soft_reset = soft_reset_q;
   assign core_clk_en = core_clk_en_q;
   assign pll_cfg = pll_q;
   assign shutter_cfg = shut_q;
   assign readout_cfg = ro_q;

endmodule : sensor_clock_reset_setup

// file: dv/spi_host_model.sv
// Host controller model: issues 16-bit serial register frames, tracks the bank.
// Assumes the device samples sclk, cs_n and mosi with its own clock.
`timescale 1ns/1ps
`include "sensor_setup_regs.svh"
module spi_host_model (
   input wire logic mclk,
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   logic [1:0] bank_q = 2'h0;
   logic [7:0] rd_byte;
   event rd_done;

   // Idle levels: link clock stands low between frames
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // One frame: direction bit, address then data, MSB first
   task automatic frame(input logic is_wr, input logic [6:0] a, input logic [7:0] d);
      logic [15:0] sh;
      sh = {is_wr, a, d};
      @(negedge mclk);
      cs_n = 1'b0;
      #63.75; // Keeps every link edge after the cs_n fall off an mclk edge
      for (int i = 15; i >= 0; i--) begin
         mosi = sh[i];
         #62.5 sclk = 1'b1;
         if (i < 8) rd_byte[i] = miso;
         #62.5 sclk = 1'b0;
      end
      mosi = ~mosi; // No stale level after release
      cs_n = 1'b1;
      #100;
   endtask : frame

   // Bank select only when the target bank changes
   task automatic wr(input logic [1:0] b, input logic [6:0] a, input logic [7:0] d);
      if (b != bank_q) frame(1'b1, `ADDR_BANK_SEL, {6'h00, b});
      bank_q = b;
      frame(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [1:0] b, input logic [6:0] a);
      if (b != bank_q) frame(1'b1, `ADDR_BANK_SEL, {6'h00, b});
      bank_q = b;
      frame(1'b0, a, 8'h00);
      ->rd_done;
   endtask : rd
endmodule : spi_host_model

// file: dv/sensor_setup_checker.sv
// Port checks of the sensor setup block.
// Assumes mclk and synchronous active-low rst_n.
`timescale 1ns/1ps
module sensor_setup_checker (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic pll1_lock_raw,
   input wire logic pll2_lock_raw,
   input wire logic test_out_pin,
   input wire logic soft_reset,
   input wire logic core_clk_en,
   input wire sensor_setup_pkg::pll_cfg_s pll_cfg,
   input wire sensor_setup_pkg::shutter_s shutter_cfg,
   input wire sensor_setup_pkg::readout_s readout_cfg
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // Clock gating versus soft reset and lock, test pin versus lock
   a_clk_not_reset: assert property (core_clk_en |-> !soft_reset)
      else $error("clock enabled in soft reset");
   a_clk_needs_lock: assert property (!pll1_lock_raw [*5] |=> !core_clk_en)
      else $error("clock enabled without lock");
   a_pin_quiet: assert property ((!pll1_lock_raw && !pll2_lock_raw) [*5] |=> !test_out_pin)
      else $error("test pin high without lock");
   // Only legal codes are ever held
   a_chan_legal: assert property (readout_cfg.channel_count inside
      {8'h16, 8'h0b, 8'h08, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01})
      else $error("illegal channel count held");
   a_scheme_legal: assert property (readout_cfg.control_scheme <= 8'h03)
      else $error("illegal control scheme held");
   // No setting changes and no read drive without a frame
   a_cfg_hold: assert property (cs_n [*8] |=> $stable({pll_cfg, shutter_cfg, readout_cfg}))
      else $error("config changed between frames");
   a_oe_idle: assert property (cs_n [*5] |=> !miso_oe)
      else $error("read driver on between frames");
   a_reset_state: assert property ($rose(rst_n) |-> soft_reset && !core_clk_en &&
      readout_cfg.channel_count == 8'h16)
      else $error("wrong state after reset");
endmodule : sensor_setup_checker

bind sensor_clock_reset_setup sensor_setup_checker chk (.mclk(mclk), .rst_n(rst_n),
   .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
   .pll1_lock_raw(pll1_lock_raw), .pll2_lock_raw(pll2_lock_raw),
   .test_out_pin(test_out_pin), .soft_reset(soft_reset), .core_clk_en(core_clk_en),
   .pll_cfg(pll_cfg), .shutter_cfg(shutter_cfg), .readout_cfg(readout_cfg));

// file: dv/sensor_clock_reset_setup_test.sv
// Self-checking bench of the sensor setup block, driven through the host model.
// Assumes 100 MHz mclk; lock flags are driven by the bench.
`timescale 1ns/1ps
`include "sensor_setup_regs.svh"
`define CHK(e, g) begin checks_done++; if ((e) !== (g)) begin num_errors++; \
   $display("BAD %0t exp %h got %h", $time, e, g); end end
module sensor_clock_reset_setup_test;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic l1 = 1'b0;
   logic l2 = 1'b0;
   logic sclk, cs_n, mosi, miso, miso_oe, tpin, srst, cen;
   logic [7:0] want;
   sensor_setup_pkg::pll_cfg_s pll;
   sensor_setup_pkg::shutter_s shut;
   sensor_setup_pkg::readout_s ro;
   int num_errors = 0;
   int checks_done = 0;
   int seed = 32'h3fce5631;
   logic [7:0] exp_q [$];
   logic [7:0] chans [9] = '{8'h16, 8'h0b, 8'h08, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01};
   logic [23:0] fmts [2] = '{24'h050207, 24'h010714};

   // Clock
   always #5 mclk = ~mclk;

   spi_host_model host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
   sensor_clock_reset_setup dut (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
      .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .pll1_lock_raw(l1), .pll2_lock_raw(l2),
      .test_out_pin(tpin), .soft_reset(srst), .core_clk_en(cen), .pll_cfg(pll),
      .shutter_cfg(shut), .readout_cfg(ro));

   // Each finished read, while one is pending, meets the oldest expectation
   always @(host.rd_done) begin
      if (exp_q.size() > 0) begin
         want = exp_q.pop_front();
         `CHK(want, host.rd_byte)
      end
   end

   task automatic rd_exp(input logic [1:0] b, input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(b, a);
   endtask : rd_exp

   task automatic give_verdict;
      if (num_errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   // Run limit
   initial begin
      #800us;
      num_errors++;
      give_verdict();
   end

   initial begin
      int fin, rate, pd, rs, mm, am, lp, tg, gr;
      logic [7:0] got;
      repeat (16) @(negedge mclk);
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      `CHK(3'b101, {srst, cen, ro.channel_count == 8'h16})
      // Lock status and test pin for every lock combination
      for (int k = 0; k < 4; k++) begin
         @(negedge mclk);
         {l2, l1} = k[1:0];
         rd_exp(2'h0, `ADDR_LOCK_STATE, {6'h00, k[1:0]});
         host.wr(2'h0, `ADDR_TEST_MUX, `TMUX_PLL1_LOCK);
         `CHK(l1, tpin)
         host.wr(2'h0, `ADDR_TEST_MUX, `TMUX_PLL2_LOCK);
         `CHK(l2, tpin)
      end
      host.wr(2'h0, `ADDR_LOCK_STATE, 8'h00);
      rd_exp(2'h0, `ADDR_LOCK_STATE, 8'h03);
      @(negedge mclk);
      {l2, l1} = 2'b00;
      // Loop setup from a random reference and target rate
      fin = 6 + int'($unsigned($random(seed)) % 91);
      rate = 120 + int'($unsigned($random(seed)) % 711);
      pd = (fin < 12) ? 0 : (fin < 24) ? 1 : (fin < 48) ? 2 : 3;
      rs = (rate >= 460) ? 0 : (rate >= 230) ? 1 : 2;
      mm = ((1 << pd) * (1 << rs) * rate) / fin;
      am = ((1 << pd) * 640) / fin;
      host.wr(2'h0, `ADDR_PLL1_EN, 8'h00);
      host.wr(2'h0, `ADDR_PLL2_EN, 8'h00);
      host.wr(2'h0, `ADDR_PLL_COMMON_EN, 8'h00);
      host.wr(2'h0, `ADDR_PREDIV, 8'(pd));
      host.wr(2'h0, `ADDR_RATE_SEL, 8'(rs));
      host.wr(2'h0, `ADDR_MAIN_MULT, 8'(mm));
      host.wr(2'h0, `ADDR_AUX_MULT, 8'(am));
      `CHK(3'b000, {pll.pll1_en, pll.pll2_en, pll.common_en})
      host.wr(2'h0, `ADDR_PLL_COMMON_EN, 8'h01);
      host.wr(2'h0, `ADDR_PLL1_EN, 8'h01);
      host.wr(2'h0, `ADDR_PLL2_EN, 8'h01);
      `CHK({3'b111, 8'(pd), 8'(rs), 8'(mm), 8'(am)}, pll)
      // Loops lock some time after enabling; poll under a bounded count
      fork
         begin
            #20us;
            @(negedge mclk);
            {l2, l1} = 2'b11;
         end
      join_none
      got = 8'h00;
      for (int n = 0; n < 120 && got !== 8'h03; n++) begin
         host.rd(2'h0, `ADDR_LOCK_STATE);
         got = host.rd_byte;
      end
      if (got !== 8'h03) begin
         num_errors++;
         give_verdict();
      end
      // Soft reset release then reassert
      host.wr(2'h3, `ADDR_SRST_HOLD, 8'h01);
      host.wr(2'h0, `ADDR_CLK_RELEASE, 8'h01);
      `CHK(2'b10, {srst, cen})
      host.wr(2'h3, `ADDR_SRST_HOLD, 8'h00);
      `CHK(2'b01, {srst, cen})
      host.wr(2'h0, `ADDR_CLK_RELEASE, 8'h00);
      `CHK(2'b10, {srst, cen})
      host.wr(2'h3, `ADDR_SRST_HOLD, 8'h01);
      `CHK(5'b10111, {srst, cen, pll.pll1_en, pll.pll2_en, pll.common_en})
      // Shutter timing from the conversion clock, 370 line period
      lp = 370;
      host.wr(2'h0, `ADDR_LINE_LO, 8'(lp));
      host.wr(2'h0, `ADDR_LINE_HI, 8'(lp >> 8));
      gr = 69 * rate / 830;
      tg = gr * 17 + lp - ((gr * 17 + 1) % lp);
      host.wr(2'h1, `ADDR_GRANULE, 8'(gr));
      host.wr(2'h1, `ADDR_TG_LO, 8'(tg));
      host.wr(2'h1, `ADDR_TG_HI, 8'(tg >> 8));
      host.wr(2'h1, `ADDR_SLAG_LO, 8'(gr * 96));
      host.wr(2'h1, `ADDR_SLAG_HI, 8'((gr * 96) >> 8));
      host.wr(2'h1, `ADDR_DUMMIES, 8'((17 * gr + lp - 1) / lp + 1));
      `CHK({8'(gr), 4'((17 * gr + lp - 1) / lp + 1), 14'(tg), 14'(gr * 96)}, shut)
      // Every channel count, an illegal one after it, packet line period
      foreach (chans[i]) begin
         host.wr(2'h0, `ADDR_CHAN_COUNT, chans[i]);
         host.wr(2'h0, `ADDR_CHAN_COUNT, 8'h07);
         rd_exp(2'h0, `ADDR_CHAN_COUNT, chans[i]);
         lp = (chans[i] == 8'h16) ? 383 : 400 * ((22 + chans[i] - 1) / chans[i]);
         host.wr(2'h0, `ADDR_LINE_LO, 8'(lp));
         host.wr(2'h0, `ADDR_LINE_HI, 8'(lp >> 8));
         `CHK(16'(lp), ro.line_period)
      end
      // Pixel and packet interface settings
      foreach (fmts[f]) begin
         host.wr(2'h3, `ADDR_IFACE_0, fmts[f][23:16]);
         host.wr(2'h3, `ADDR_IFACE_1, fmts[f][15:8]);
         host.wr(2'h3, `ADDR_IFACE_2, fmts[f][7:0]);
         `CHK(fmts[f], {ro.iface0, ro.iface1, ro.iface2})
      end
      // Control schemes, one beyond range refused
      for (int s = 0; s < 5; s++) begin
         host.wr(2'h0, `ADDR_CTRL_SCHEME, 8'(s));
         rd_exp(2'h0, `ADDR_CTRL_SCHEME, (s < 4) ? 8'(s) : 8'h03);
      end
      // Unused bank stores nothing
      host.wr(2'h2, 7'h10, 8'h5a);
      rd_exp(2'h2, 7'h10, 8'h00);
      @(negedge mclk); // Let the last read be compared
      if (exp_q.size() != 0) begin
         num_errors++;
      end
      give_verdict();
   end
endmodule : sensor_clock_reset_setup_test
